// File: pfh_flash_model.sv
/*
 Behavioural byte-wide flash for the host bench: array, unlock decode,
 program with polling status, id codes, time-limit fault and supply lockout.
 Assumes pins come straight from pfh_host and bus is the resolved data wire.
*/
`timescale 1ns/1ps
`default_nettype none
module pfh_flash_model
    import pfh_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'hA5, // Arbitrary value
    parameter logic [7:0] DEV_CODE   = 8'h3B  // Arbitrary value
)(
    input  wire pfh_pins_t  pins,
    input  wire logic [7:0] bus,
    input  wire logic       lockout,
    input  wire logic       tlim_en,
    input  wire logic       susp,
    output logic      [7:0] dq
);
    logic [7:0]    mem [0:255];
    logic [AW-1:0] wa;
    logic [7:0]    rd, last, pd;
    logic [1:0]    ulk;
    logic          idm, pgm, tgl;
    int            busy;
    realtime       t_fall;
    wire a_hi = pins.addr[18:16] == 3'h7;
    wire wr_n = pins.chip_sel_n | pins.write_strobe_n | ~pins.out_drive_n;
    wire drv  = !pins.chip_sel_n && !pins.out_drive_n && pins.write_strobe_n;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
        {ulk, idm, pgm, tgl, busy, last} = '0;
    end
    always @(negedge wr_n) begin
        wa = pins.addr;
        t_fall = $realtime;
    end
    always @(posedge wr_n or posedge lockout) begin
        if (lockout) begin
            {ulk, idm, pgm, busy} = '0;
        end else if ($realtime - t_fall < 5.0) begin
            // Glitch, not a write
        end else if (busy > 0) begin
        end else if (!pgm && bus == CMD_RESET) begin
            {ulk, idm, busy} = '0;
        end else if (busy < 0) begin
        end else if (pgm) begin
            pgm = 0;
            if (wa[18:16] != 3'h7) begin
                mem[wa[7:0]] &= bus;
                pd = bus;
                busy = tlim_en ? -1 : 3;
            end
        end else if (ulk == 0 && wa == UNLOCK_A1 && bus == UNLOCK_D1) ulk = 1;
        else if (ulk == 1 && wa == UNLOCK_A2 && bus == UNLOCK_D2) ulk = 2;
        else if (ulk == 2 && wa == UNLOCK_A1) begin
            ulk = 0;
            idm = bus == CMD_ID;
            pgm = bus == CMD_PROG;
        end else ulk = 0;
    end
    // Status reads pace the operation, so polling speed does not matter
    always @(posedge drv) begin
        if (busy != 0) tgl = ~tgl;
        if (busy > 0) busy--;
    end
    always @* begin
        if (busy != 0) rd = {~pd[7], tgl, busy < 0, 5'h00};
        // Sector 6 stands in for an erase-suspended sector
        else if (susp && pins.addr[18:16] == 3'h6) rd = 8'h80;
        else if (idm || pins.id_hv_en)
            rd = pins.addr[1:0] == 2'd0 ? MAKER_CODE : pins.addr[1:0] == 2'd1 ? DEV_CODE : {7'h00, a_hi};
        else rd = mem[pins.addr[7:0]];
    end
    always @(rd or drv) if (drv) last = rd;
    // Released bus shows the inverse, never a stale match
    assign dq = drv ? rd : ~last;
endmodule : pfh_flash_model
`default_nettype wire

// File: pfh_host.sv
/*
 Host controller for an asynchronous byte-wide parallel flash, with APB
 registers for software.
 Assumes the flash pins are wired straight to pins and dq_in is asynchronous.
*/
// Local design decisions: the address map and the APB slave port.
// Notes on behaviour
// RULE_01 - Device floats data pins while chip-select is high.
// RULE_02 - Device reads array after power-up without any command.
// RULE_03 - Device returns to array reads after program or erase.
// RULE_04 - Erase-suspended sectors read status; others read array data.
// RULE_05 - Program during suspend returns to suspended read behaviour.
// RULE_06 - Host writes reset command when time-limit flag seen, or leaving id mode.
// RULE_07 - Device floats outputs when chip-select or output-drive is high.
// RULE_08 - In id mode device drives maker, device or protection bytes.
// RULE_09 - Pin id mode: host holds high voltage on id line, sets selector bits.
// RULE_10 - Id mode can be entered by command sequence without high voltage.
// RULE_11 - Write cycle: address and data valid, chip-select and strobe low, output-drive high.
// RULE_12 - Address latched on later falling edge, data on earlier rising edge.
// RULE_13 - Device times its own program and erase pulses.
// RULE_14 - Completion shown by polled and toggling status bits; host reads them.
// RULE_15 - Device refuses program or erase in protected sectors.
// RULE_16 - Device sleeps on stable address, keeps last data latched.
// RULE_17 - Device needs unlock cycles before any program or erase.
// RULE_18 - Device rejects writes while supply lockout is active.
// RULE_19 - Control pulses under about 5 ns never start a write.
// RULE_20 - Writes inhibited by control levels; all three low is neither a read nor a write.
// RULE_21 - Device locks out writes during power-up.
// RULE_22 - Device drives data only with chip-select and output-drive low, strobe high.
`timescale 1ns/1ps
`default_nettype none
module pfh_host
    import pfh_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  dq_in,
    output var pfh_pins_t    pins
);
    pfh_state_t     state_reg, state_next;
    pfh_op_t        op_reg;
    logic [1:0]     step_reg;
    logic [3:0]     cnt_reg;
    logic [AW-1:0]  addr_reg;
    logic [7:0]     wdata_reg;
    logic [7:0]     rdata_reg;
    logic [7:0]     prev_reg;
    logic           first_reg;
    logic           done_reg;
    logic           tlim_reg;
    logic           hv_reg;
    logic [7:0]     sync1_reg, sync2_reg;
    logic [31:0]    prdata_reg;
    logic           slverr_reg;
    logic [AW-1:0]  addr_drive_reg;
    logic [7:0]     dq_out_reg;
    logic           dq_oe_reg, cs_n_reg, oe_n_reg, we_n_reg;
    logic           prev_valid;

    // APB decode
    wire apb_setup  = psel && !penable;
    wire apb_wr     = psel && penable && pwrite;
    wire hit_cmd    = paddr == OFS_CMD;
    wire hit_addr   = paddr == OFS_ADDR;
    wire hit_wdata  = paddr == OFS_WDATA;
    wire hit_status = paddr == OFS_STATUS;
    wire hit_cfg    = paddr == OFS_CFG;
    wire hit_any    = hit_cmd || hit_addr || hit_wdata || hit_status || hit_cfg;
    wire busy       = state_reg != S_IDLE;
    // Commands while busy are dropped rather than queued
    wire start      = apb_wr && hit_cmd && !busy;
    wire pfh_op_t new_op = pfh_op_t'(pwdata[2:0]);

    wire [31:0] status_word = {16'h0000, rdata_reg, 5'h00, tlim_reg, done_reg, busy};
    wire [31:0] rd_mux = hit_cmd    ? {29'h0, op_reg} :
                         hit_addr   ? {13'h0, addr_reg} :
                         hit_wdata  ? {24'h0, wdata_reg} :
                         hit_status ? status_word :
                         hit_cfg    ? {31'h0, hv_reg} : 32'h0000_0000;

    // Unlock sequence, then the command byte, then the user cycle
    wire            is_rd     = op_reg == OP_READ;
    wire            polling   = op_reg == OP_PROG;
    wire [1:0]      last_step = (op_reg == OP_ID) ? STEP_CMD : STEP_USER;
    wire            cnt_done  = cnt_reg == 4'h0;
    wire            toggled   = sync2_reg[TOGGLE_BIT] != prev_reg[TOGGLE_BIT];
    wire            tlim_seen = toggled && sync2_reg[TLIM_BIT];
    // Pins load on the edge that moves op and step, so decode their next values
    wire            kick      = state_reg == S_IDLE && start;
    wire            tlim_hit  = state_reg == S_CHECK && polling && prev_valid && tlim_seen;
    wire            advance   = state_reg == S_HOLD && step_reg != last_step;
    wire            multi_op  = new_op == OP_ID || new_op == OP_PROG;
    wire pfh_op_t   op_nxt    = kick ? new_op : tlim_hit ? OP_RESET : op_reg;
    wire [1:0]      step_nxt  = kick ? (multi_op ? 2'd0 : STEP_USER) : advance ? step_reg + 2'd1 : step_reg;
    wire [AW-1:0]   cyc_addr  = (step_nxt == STEP_USER) ? addr_reg :
                                step_nxt[0] ? UNLOCK_A2 : UNLOCK_A1;
    wire [7:0]      cmd_byte  = (op_nxt == OP_ID) ? CMD_ID : CMD_PROG;
    wire [7:0]      cyc_data  = (step_nxt == STEP_USER) ? ((op_nxt == OP_RESET) ? CMD_RESET : wdata_reg) :
                                (step_nxt == STEP_CMD)  ? cmd_byte :
                                step_nxt[0] ? UNLOCK_D2 : UNLOCK_D1;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE:   state_next = start ? S_SETUP : S_IDLE;
            S_SETUP:  state_next = (is_rd || (polling && first_reg)) ? S_READ : S_STROBE;
            S_STROBE: state_next = cnt_done ? S_HOLD : S_STROBE;
            S_HOLD:   state_next = (step_reg != last_step) ? S_SETUP :
                                   polling ? S_SETUP : S_IDLE;
            S_READ:   state_next = cnt_done ? S_CHECK : S_READ;
            S_CHECK:  state_next = is_rd ? S_IDLE :
                                   (!polling) ? S_IDLE :
                                   (first_reg && prev_valid && !toggled) ? S_IDLE : S_SETUP;
            default:  state_next = S_IDLE;
        endcase
    end

    // Pin drive; a read never lowers the write strobe
    assign pins.addr           = addr_drive_reg;
    assign pins.dq_out         = dq_out_reg;
    assign pins.dq_oe          = dq_oe_reg;
    assign pins.chip_sel_n     = cs_n_reg;
    assign pins.out_drive_n    = oe_n_reg;
    assign pins.write_strobe_n = we_n_reg;
    assign pins.id_hv_en       = hv_reg; // RULE_09
    assign prdata              = prdata_reg;
    assign pready              = 1'b1;
    assign pslverr             = slverr_reg;

    // Two-flop capture of the asynchronous data bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
        end else if (clk_en) begin
            sync1_reg <= dq_in;
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            slverr_reg <= 1'b0;
            addr_reg   <= '0;
            wdata_reg  <= 8'h00;
            hv_reg     <= 1'b0;
        end else if (clk_en) begin
            if (apb_setup) begin
                prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
                slverr_reg <= !hit_any;
            end
            if (apb_wr && hit_addr && !busy) addr_reg <= pwdata[AW-1:0];
            if (apb_wr && hit_wdata && !busy) wdata_reg <= pwdata[7:0];
            if (apb_wr && hit_cfg) hv_reg <= pwdata[CFG_HV];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_IDLE;
            op_reg    <= OP_READ;
            step_reg  <= 2'd0;
            cnt_reg   <= 4'h0;
            first_reg <= 1'b0;
            prev_reg  <= 8'h00;
            rdata_reg <= 8'h00;
            done_reg  <= 1'b0;
            tlim_reg  <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            cnt_reg   <= cnt_done ? 4'h0 : cnt_reg - 4'h1;
            case (state_reg)
                S_IDLE: if (start) begin
                    op_reg    <= new_op;
                    done_reg  <= 1'b0;
                    tlim_reg  <= 1'b0;
                    first_reg <= 1'b0;
                    step_reg  <= (new_op == OP_ID || new_op == OP_PROG) ? 2'd0 : STEP_USER; // RULE_10
                end
                S_SETUP:  cnt_reg <= (is_rd || (polling && first_reg)) ? RD_WAIT : WP_WAIT;
                S_HOLD: begin
                    if (step_reg != last_step) step_reg <= step_reg + 2'd1;
                    else if (polling) first_reg <= 1'b1; // RULE_14
                    else done_reg <= 1'b1;
                end
                S_CHECK: begin
                    rdata_reg <= sync2_reg;
                    prev_reg  <= sync2_reg;
                    if (is_rd || (first_reg && prev_valid && !toggled)) done_reg <= 1'b1; // RULE_14
                    if (polling && prev_valid && tlim_seen) begin
                        tlim_reg <= 1'b1;
                        op_reg   <= OP_RESET; // RULE_06
                    end
                end
                default: ;
            endcase
        end
    end

    // First poll read only primes the toggle comparison
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prev_valid <= 1'b0;
        else if (clk_en) begin
            if (state_reg == S_IDLE) prev_valid <= 1'b0;
            else if (state_reg == S_CHECK) prev_valid <= 1'b1;
        end
    end

    // Registered pins; address and data stand from setup through hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_drive_reg <= '0;
            dq_out_reg     <= 8'h00;
            dq_oe_reg      <= 1'b0;
            cs_n_reg       <= 1'b1;
            oe_n_reg       <= 1'b1;
            we_n_reg       <= 1'b1;
        end else if (clk_en) begin
            cs_n_reg <= !(state_next inside {S_SETUP, S_STROBE, S_HOLD, S_READ}); // RULE_11
            oe_n_reg <= state_next != S_READ; // RULE_20
            we_n_reg <= state_next != S_STROBE; // RULE_19
            // Data bus released before output-drive falls, so no contention
            dq_oe_reg <= state_next inside {S_STROBE, S_HOLD}; // RULE_22
            if (state_next == S_SETUP) begin
                addr_drive_reg <= (polling && first_reg) ? addr_reg : cyc_addr; // RULE_12
                dq_out_reg     <= cyc_data; // RULE_12
            end
        end
    end

    // Polling read after the user step keeps the user address
    wire pfh_op_t op_chk = op_reg;

    a_no_all_low: assert property (@(posedge pclk) disable iff (!presetn) // RULE_20
        !(!pins.chip_sel_n && !pins.out_drive_n && !pins.write_strobe_n))
        else $error("all three controls low");
    a_write_levels: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
        !pins.write_strobe_n |-> !pins.chip_sel_n && pins.out_drive_n && pins.dq_oe)
        else $error("bad write levels");
    a_strobe_width: assert property (@(posedge pclk) disable iff (!presetn || !clk_en) // RULE_19
        $fell(pins.write_strobe_n) |-> !pins.write_strobe_n [*2])
        else $error("strobe too short");
    a_no_drive_read: assert property (@(posedge pclk) disable iff (!presetn) // RULE_22
        !pins.out_drive_n |-> !pins.dq_oe)
        else $error("driving during read");
    a_strobe_stable: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
        !pins.write_strobe_n && !$fell(pins.write_strobe_n) |-> $stable(pins.addr) && $stable(pins.dq_out))
        else $error("addr or data moved in strobe");
    a_tlim_reset: assert property (@(posedge pclk) disable iff (!presetn || !clk_en) // RULE_06
        state_reg == S_CHECK && polling && prev_valid && tlim_seen |=> op_reg == OP_RESET && tlim_reg)
        else $error("no reset after time limit");
    a_id_sequence: assert property (@(posedge pclk) disable iff (!presetn || !clk_en) // RULE_10
        state_reg == S_HOLD && op_chk == OP_ID && step_reg == STEP_CMD |=> state_reg == S_IDLE && done_reg)
        else $error("id entry did not finish");
    a_poll_done: assert property (@(posedge pclk) disable iff (!presetn || !clk_en) // RULE_14
        $rose(done_reg) && op_chk == OP_PROG |-> $past(state_reg) == S_CHECK && !$past(toggled))
        else $error("done without stable toggle");

    // Pin sequencing; setup and hold are whole pclk cycles, never edge-aligned
    a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn) // RULE_20
        state_reg == S_IDLE |-> pins.chip_sel_n)
        else $error("chip select low while idle");
    a_standby_float: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
        pins.chip_sel_n |-> !pins.dq_oe && pins.write_strobe_n && pins.out_drive_n)
        else $error("pins active without chip select");
    a_read_strobe: assert property (@(posedge pclk) disable iff (!presetn) // RULE_22
        !pins.out_drive_n |-> pins.write_strobe_n && !pins.chip_sel_n)
        else $error("bad read levels");
    a_oe_after_cs: assert property (@(posedge pclk) disable iff (!presetn || !clk_en) // RULE_22
        $fell(pins.out_drive_n) |-> !$past(pins.chip_sel_n))
        else $error("output drive before chip select");
    a_addr_setup: assert property (@(posedge pclk) disable iff (!presetn || !clk_en) // RULE_11
        $fell(pins.write_strobe_n) |-> $stable(pins.addr) && $stable(pins.dq_out) && !$past(pins.chip_sel_n))
        else $error("no setup before strobe");
    a_data_hold: assert property (@(posedge pclk) disable iff (!presetn || !clk_en) // RULE_12
        $rose(pins.write_strobe_n) |-> !pins.chip_sel_n && pins.dq_oe && $stable(pins.dq_out))
        else $error("data dropped at strobe rise");
    a_unlock_first: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
        state_reg == S_STROBE && step_reg == 2'd0 |-> pins.addr == UNLOCK_A1 && pins.dq_out == UNLOCK_D1)
        else $error("bad first unlock cycle");
    a_unlock_second: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
        state_reg == S_STROBE && step_reg == 2'd1 |-> pins.addr == UNLOCK_A2 && pins.dq_out == UNLOCK_D2)
        else $error("bad second unlock cycle");
    a_reset_byte: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
        state_reg == S_STROBE && op_chk == OP_RESET |-> pins.dq_out == CMD_RESET && pins.addr == addr_reg)
        else $error("bad reset command cycle");
    a_read_addr: assert property (@(posedge pclk) disable iff (!presetn) // RULE_14
        state_reg == S_READ |-> pins.addr == addr_reg)
        else $error("read not at user address");
    a_poll_prime: assert property (@(posedge pclk) disable iff (!presetn || !clk_en) // RULE_14
        state_reg == S_CHECK && polling && !prev_valid |=> state_reg == S_SETUP)
        else $error("first poll ended the operation");
    a_start_clears: assert property (@(posedge pclk) disable iff (!presetn || !clk_en) // RULE_14
        start |=> !done_reg && !tlim_reg)
        else $error("flags not cleared at start");
endmodule : pfh_host
`default_nettype wire

// File: pfh_host_tb.sv
/*
 Self-checking bench for pfh_host: APB master tasks, flash model on the pins.
 Assumes pready comes back without a fixed cycle count.
*/
`timescale 1ns/1ps
`default_nettype none
module pfh_host_tb;
    import pfh_pkg::*;
    localparam logic [7:0] MK = 8'hA5; // Arbitrary value
    localparam logic [7:0] DV = 8'h3B; // Arbitrary value
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        lockout = 1, tlim_en = 0, clk_en = 1, susp = 0, pready, pslverr, ev;
    logic [7:0]  paddr = 0, flash_dq;
    logic [31:0] pwdata = 0, prdata, rv;
    wire  logic [7:0] bus;
    pfh_pins_t   pins;
    int          n_fail = 0, check_count = 0;
    assign bus = pins.dq_oe ? pins.dq_out : flash_dq;
    always #12.5 pclk = ~pclk;
    pfh_host DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dq_in(bus), .pins(pins));
    pfh_flash_model #(.MAKER_CODE(MK), .DEV_CODE(DV)) FLASH (.pins(pins), .bus(bus),
        .lockout(lockout), .tlim_en(tlim_en), .susp(susp), .dq(flash_dq));
    task automatic test_done();
        if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    task automatic run(input logic [2:0] op, input logic [18:0] a, input logic [7:0] d);
        int i;
        apb(1, OFS_ADDR, 32'(a));
        apb(1, OFS_WDATA, 32'(d));
        apb(1, OFS_CMD, 32'(op));
        i = 0;
        do begin apb(0, OFS_STATUS, 0); i++; end while (rv[ST_DONE] !== 1'b1 && i < 200);
        chk(32'({rv[ST_BUSY], rv[ST_DONE]}), 32'h1);
    endtask : run
    task automatic t_regs();
        apb(0, 8'h40, 32'h0);
        chk({31'h0, ev}, 32'h1);
        chk(rv, 32'h0);
        apb(1, OFS_ADDR, 32'hFFFF_FFFF);
        apb(0, OFS_ADDR, 32'h0);
        chk(rv, 32'h0007_FFFF);
        // Frozen block must drop the write
        clk_en <= 0;
        apb(1, OFS_ADDR, 32'h0);
        clk_en <= 1;
        apb(0, OFS_ADDR, 32'h0);
        chk(rv, 32'h0007_FFFF);
        apb(1, OFS_CFG, 32'hFFFF_FFFF);
        apb(0, OFS_CFG, 32'h0);
        chk(rv, 32'h1);
        chk({31'h0, pins.id_hv_en}, 32'h1);
        apb(1, OFS_CFG, 32'h0);
    endtask : t_regs
    task automatic t_read();
        run(OP_READ, 19'h00033, 8'h00);
        chk(32'(rv[15:8]), 32'(8'h33 ^ 8'h5A));
    endtask : t_read
    task automatic t_prog();
        run(OP_PROG, 19'h00012, 8'h3C);
        chk(32'(rv[ST_TLIM]), 32'h0);
        run(OP_READ, 19'h00012, 8'h00);
        chk(32'(rv[15:8]), 32'((8'h12 ^ 8'h5A) & 8'h3C));
        // Lone write without unlock must leave the byte alone
        run(OP_WRITE, 19'h00020, 8'h00);
        run(OP_READ, 19'h00020, 8'h00);
        chk(32'(rv[15:8]), 32'(8'h20 ^ 8'h5A));
    endtask : t_prog
    task automatic t_refused(input logic [18:0] a, input logic lk);
        lockout <= lk;
        run(OP_PROG, a, 8'h00);
        lockout <= 0;
        run(OP_READ, a, 8'h00);
        chk(32'(rv[15:8]), 32'(a[7:0] ^ 8'h5A));
    endtask : t_refused
    task automatic t_id(input logic hv);
        logic [18:0] ia [4];
        logic [7:0]  ie [4];
        ia = '{19'h00000, 19'h00001, 19'h70002, 19'h00002};
        ie = '{MK, DV, 8'h01, 8'h00};
        if (hv) apb(1, OFS_CFG, 32'h1);
        else run(OP_ID, 19'h00000, 8'h00);
        for (int k = 0; k < 4; k++) begin
            run(OP_READ, ia[k], 8'h00);
            chk(32'(rv[15:8]), 32'(ie[k]));
        end
        if (hv) apb(1, OFS_CFG, 32'h0);
        else run(OP_RESET, 19'h00000, 8'h00);
        run(OP_READ, 19'h00033, 8'h00);
        chk(32'(rv[15:8]), 32'(8'h33 ^ 8'h5A));
    endtask : t_id
    task automatic t_tlim();
        tlim_en <= 1;
        run(OP_PROG, 19'h00044, 8'h00);
        tlim_en <= 0;
        chk(32'(rv[ST_TLIM]), 32'h1);
        run(OP_READ, 19'h00044, 8'h00);
        chk(32'(rv[15:8]), 32'h0);
    endtask : t_tlim
    task automatic t_susp();
        susp <= 1;
        run(OP_READ, 19'h60033, 8'h00);
        chk(32'(rv[15:8]), 32'h80);
        run(OP_READ, 19'h50033, 8'h00);
        chk(32'(rv[15:8]), 32'(8'h33 ^ 8'h5A));
        run(OP_PROG, 19'h00055, 8'h0F);
        run(OP_READ, 19'h00055, 8'h00);
        chk(32'(rv[15:8]), 32'((8'h55 ^ 8'h5A) & 8'h0F));
        run(OP_READ, 19'h60033, 8'h00);
        chk(32'(rv[15:8]), 32'h80);
        susp <= 0;
    endtask : t_susp
    initial begin
        #400000;
        n_fail++;
        test_done();
    end
    initial begin
        repeat (6) @(posedge pclk);
        chk(32'({pins.chip_sel_n, pins.out_drive_n, pins.write_strobe_n, pins.dq_oe}), 32'hE);
        presetn <= 1;
        // Lockout held over reset stands in for power-up
        lockout <= 0;
        t_read();
        t_regs();
        t_prog();
        t_refused(19'h70010, 1'b0);
        t_refused(19'h00050, 1'b1);
        t_id(1'b0);
        t_id(1'b1);
        t_susp();
        t_tlim();
        test_done();
    end
endmodule : pfh_host_tb
`default_nettype wire

// File: pfh_pkg.sv
/*
 Package for the parallel flash host controller: register map, fields, ops,
 states, pin bundle and cycle counts.
 Assumes a 40 MHz pclk.
*/
`default_nettype none
package pfh_pkg;
    localparam int          CLK_MHZ     = 40;
    localparam int          T_ACC_NS    = 70;
    localparam int          T_WP_NS     = 35;
    localparam int          SYNC_CYC    = 2;
    // Least times round up
    localparam int          ACC_CYC     = (T_ACC_NS * CLK_MHZ + 999) / 1000;
    localparam int          WP_CYC      = (T_WP_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0]  RD_WAIT     = 4'(ACC_CYC + SYNC_CYC);
    localparam logic [3:0]  WP_WAIT     = 4'(WP_CYC);
    localparam int          AW          = 19;
    localparam logic [7:0]  OFS_CMD     = 8'h00;
    localparam logic [7:0]  OFS_ADDR    = 8'h04;
    localparam logic [7:0]  OFS_WDATA   = 8'h08;
    localparam logic [7:0]  OFS_STATUS  = 8'h0C;
    localparam logic [7:0]  OFS_CFG     = 8'h10;
    localparam int          ST_BUSY     = 0;
    localparam int          ST_DONE     = 1;
    localparam int          ST_TLIM     = 2;
    localparam int          ST_RD_LSB   = 8;
    localparam int          CFG_HV      = 0;
    localparam int          TOGGLE_BIT  = 6;
    localparam int          TLIM_BIT    = 5;
    localparam logic [AW-1:0] UNLOCK_A1 = 19'h00555;
    localparam logic [AW-1:0] UNLOCK_A2 = 19'h002AA;
    localparam logic [7:0]  UNLOCK_D1   = 8'hAA;
    localparam logic [7:0]  UNLOCK_D2   = 8'h55;
    localparam logic [7:0]  CMD_PROG    = 8'hA0;
    localparam logic [7:0]  CMD_ID      = 8'h90;
    localparam logic [7:0]  CMD_RESET   = 8'hF0;
    localparam logic [1:0]  STEP_CMD    = 2'd2;
    localparam logic [1:0]  STEP_USER   = 2'd3;

    typedef enum logic [2:0] {
        OP_READ  = 3'h0,
        OP_WRITE = 3'h1,
        OP_RESET = 3'h2,
        OP_ID    = 3'h3,
        OP_PROG  = 3'h4
    } pfh_op_t;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_SETUP  = 3'b001,
        S_STROBE = 3'b011,
        S_HOLD   = 3'b010,
        S_READ   = 3'b110,
        S_CHECK  = 3'b111
    } pfh_state_t;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [7:0]    dq_out;
        logic          dq_oe;
        logic          chip_sel_n;
        logic          out_drive_n;
        logic          write_strobe_n;
        logic          id_hv_en;
    } pfh_pins_t;
endpackage : pfh_pkg
`default_nettype wire
